// >>> inc/driver_spi_consts.vh
/*
  Field positions, reset values and timing counts for the load driver's serial
  control and status map. Included by the driver map only; the pin synchroniser does not use it.
*/
`ifndef DRIVER_SPI_CONSTS_VH
`define DRIVER_SPI_CONSTS_VH

// Frame
`define FRAME_BITS          16
`define FRAME_CNT_W         5
`define BIT_REG_SELECT      0
`define BIT_STATUS_ONE      15

// Drive command register (select = 0)
`define BIT_DRIVE_LO        1
`define BIT_SUPPLY_RECOV_DIS 12
`define BIT_DUTY_SELECT     13
`define BIT_OPEN_LOAD_DIS   14
`define BIT_STATUS_CLEAR    15

// Option config register (select = 1), one bit per output number 1..5
`define BIT_PWM_EN_LO       1
`define BIT_OC_RECOV_LO     6
`define OPTION_USED_MSB     10

// Supply and thermal status register
`define BIT_OVER_VOLT       14
`define BIT_UNDER_VOLT      13
`define BIT_THERMAL_SD      12
`define BIT_THERMAL_WARN    11

// Reset values
`define DRIVE_CMD_RESET     16'h0000
`define OPTION_CFG_RESET    16'h0000

// Over-current recovery timing
`define CLK_PERIOD_NS       8
`define RECOV_PERIOD_NS     100000
`define DUTY_LOW_PCT        12
`define DUTY_HIGH_PCT       25

`endif

// >>> rtl/pin_sync.v
/*
  Two-stage synchroniser for a bundle of asynchronous pin levels.
  Assumes each bit is an independent level; no word coherence is given.
*/
`default_nettype none

module pin_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             sys_rst,
   // Levels
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_reg;

   // First stage feeds only the second stage
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         meta_reg <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// >>> rtl/driver_spi_control_status_map.v
/*
  Serial control and status map of a multi-output load driver: frame receiver
  and status shifter, command registers, fault flags and output gating.
  Assumes the serial pins, PWM pin and analog fault detectors are asynchronous
  levels; the serial clock is sampled by clk_sys, so it must be well below it.
*/
`default_nettype none
`include "driver_spi_consts.vh"

module driver_spi_control_status_map #(
   parameter NUM_OUT      = 8,
   parameter RECOV_CYCLES = `RECOV_PERIOD_NS / `CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire               clk_sys,
   input  wire               sys_rst,
   // Serial link
   input  wire               serial_clk_pin,
   input  wire               chip_select_low,
   input  wire               serial_in_pin,
   output reg                serial_out_data,
   output reg                serial_out_en,
   // PWM gate
   input  wire               pwm_pin,
   // Analog fault detectors
   input  wire [NUM_OUT-1:0] over_current_in,
   input  wire               over_volt_in,
   input  wire               under_volt_in,
   input  wire               thermal_sd_in,
   input  wire               thermal_warn_in,
   // Driver gates: a_low, a_high, b_low, b_high, c_low, c_high, d, e
   output reg  [NUM_OUT-1:0] drive_on
);

   localparam SYNC_W  = NUM_OUT + 8;
   localparam RC_W    = 32;
   localparam [RC_W-1:0] ON_LOW  = (RECOV_CYCLES * `DUTY_LOW_PCT) / 100;
   localparam [RC_W-1:0] ON_HIGH = (RECOV_CYCLES * `DUTY_HIGH_PCT) / 100;
   localparam [RC_W-1:0] RC_LAST = RECOV_CYCLES - 1;

   // Output index to output number minus one (half bridges share a number)
   function [2:0] out_number;
      input integer idx;
      begin
         if (idx < 6) begin
            out_number = idx[3:1];
         end else begin
            out_number = idx[2:0] - 3'd3;
         end
      end
   endfunction

   wire [SYNC_W-1:0] sync_w;
   wire              sclk_s;
   wire              csn_s;
   wire              din_s;
   wire              pwm_s;
   wire              ov_s;
   wire              uv_s;
   wire              tsd_s;
   wire              tw_s;
   wire [NUM_OUT-1:0] oc_s;

   pin_sync #(
      .WIDTH    (SYNC_W)
   ) u_sync (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .async_in ({over_current_in, thermal_warn_in, thermal_sd_in, under_volt_in,
                  over_volt_in, pwm_pin, serial_in_pin, ~chip_select_low,
                  serial_clk_pin}),
      .sync_out (sync_w)
   );

   assign sclk_s = sync_w[0];
   // Select travels inverted so the zero reset of the synchroniser reads as idle
   assign csn_s  = ~sync_w[1];
   assign din_s  = sync_w[2];
   assign pwm_s  = sync_w[3];
   assign ov_s   = sync_w[4];
   assign uv_s   = sync_w[5];
   assign tsd_s  = sync_w[6];
   assign tw_s   = sync_w[7];
   assign oc_s   = sync_w[SYNC_W-1:8];

   reg [15:0]               drive_cmd_reg;
   reg [15:0]               option_cfg_reg;
   reg [NUM_OUT-1:0]        oc_flag_reg;
   reg                      ov_flag_reg;
   reg                      uv_flag_reg;
   reg                      tsd_flag_reg;
   reg                      tw_flag_reg;
   reg                      sclk_prev_reg;
   reg                      csn_prev_reg;
   reg [15:0]               rx_shift_reg;
   reg [15:0]               tx_snap_reg;
   reg [`FRAME_CNT_W-1:0]   bit_cnt_reg;
   reg                      status_clr_reg;
   reg [RC_W-1:0]           recov_cnt_reg;

   wire sclk_rise = sclk_s & ~sclk_prev_reg;
   wire sclk_fall = ~sclk_s & sclk_prev_reg;
   wire cs_fall   = ~csn_s & csn_prev_reg;
   wire cs_rise   = csn_s & ~csn_prev_reg;

   // Status words; open-load flags are not implemented and read as zero
   wire [15:0] fault_status;
   wire [15:0] supply_thermal_status;
   wire        any_fault;

   // Bit 14 of drive command masks open-load flags; with none held it has no effect
   assign any_fault = (|oc_flag_reg) | ov_flag_reg | uv_flag_reg | tsd_flag_reg
                      | tw_flag_reg;
   assign fault_status = {1'b1, 6'h00, oc_flag_reg, ~any_fault};
   assign supply_thermal_status = {1'b1, ov_flag_reg, uv_flag_reg, tsd_flag_reg,
                                   tw_flag_reg, 11'h000};

   // Serial frame engine: data in on rising, data out on falling, LSB first
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sclk_prev_reg   <= 1'b0;
         csn_prev_reg    <= 1'b1;
         rx_shift_reg    <= 16'h0000;
         tx_snap_reg     <= 16'h0000;
         bit_cnt_reg     <= {`FRAME_CNT_W{1'b0}};
         drive_cmd_reg   <= `DRIVE_CMD_RESET;
         option_cfg_reg  <= `OPTION_CFG_RESET;
         status_clr_reg  <= 1'b0;
         serial_out_data <= 1'b0;
         serial_out_en   <= 1'b0;
      end else begin
         sclk_prev_reg  <= sclk_s;
         csn_prev_reg   <= csn_s;
         status_clr_reg <= 1'b0;
         serial_out_en  <= ~csn_s;
         if (cs_fall) begin
            bit_cnt_reg     <= {`FRAME_CNT_W{1'b0}};
            serial_out_data <= fault_status[0];
         end else if (!csn_s) begin
            if (sclk_rise) begin
               rx_shift_reg <= {din_s, rx_shift_reg[15:1]};
               if (bit_cnt_reg != {`FRAME_CNT_W{1'b1}}) begin
                  bit_cnt_reg <= bit_cnt_reg + 1'b1;
               end
               if (bit_cnt_reg == {`FRAME_CNT_W{1'b0}}) begin
                  // First bit picks the status word shifted back this frame
                  tx_snap_reg <= din_s ? supply_thermal_status : fault_status;
               end
            end else if (sclk_fall && bit_cnt_reg < `FRAME_BITS) begin
               serial_out_data <= tx_snap_reg[bit_cnt_reg[3:0]];
            end
         end
         // Short or long frames are dropped whole
         if (cs_rise && bit_cnt_reg == `FRAME_BITS) begin
            if (rx_shift_reg[`BIT_REG_SELECT]) begin
               option_cfg_reg <= {5'h00, rx_shift_reg[`OPTION_USED_MSB:1], 1'b0};
            end else begin
               drive_cmd_reg  <= {rx_shift_reg[15:1], 1'b0};
               status_clr_reg <= rx_shift_reg[`BIT_STATUS_CLEAR];
            end
         end
      end
   end

   // Sticky fault flags; a new event in the clearing cycle keeps its flag
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         oc_flag_reg  <= {NUM_OUT{1'b0}};
         ov_flag_reg  <= 1'b0;
         uv_flag_reg  <= 1'b0;
         tsd_flag_reg <= 1'b0;
         tw_flag_reg  <= 1'b0;
      end else begin
         oc_flag_reg  <= (oc_flag_reg & ~{NUM_OUT{status_clr_reg}}) | oc_s;
         ov_flag_reg  <= (ov_flag_reg & ~status_clr_reg) | ov_s;
         uv_flag_reg  <= (uv_flag_reg & ~status_clr_reg) | uv_s;
         tsd_flag_reg <= (tsd_flag_reg & ~status_clr_reg) | tsd_s;
         tw_flag_reg  <= (tw_flag_reg & ~status_clr_reg) | tw_s;
      end
   end

   // Free-running recovery period shared by all outputs
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         recov_cnt_reg <= {RC_W{1'b0}};
      end else if (recov_cnt_reg >= RC_LAST) begin
         recov_cnt_reg <= {RC_W{1'b0}};
      end else begin
         recov_cnt_reg <= recov_cnt_reg + 1'b1;
      end
   end

   wire recov_phase_on;
   wire supply_block;
   wire global_block;

   assign recov_phase_on = recov_cnt_reg <
      (drive_cmd_reg[`BIT_DUTY_SELECT] ? ON_HIGH : ON_LOW);
   // Live supply fault always blocks; the latched flag blocks only if auto resume is off
   assign supply_block = ov_s | uv_s |
      (drive_cmd_reg[`BIT_SUPPLY_RECOV_DIS] & (ov_flag_reg | uv_flag_reg));
   assign global_block = supply_block | tsd_flag_reg;

   reg [NUM_OUT-1:0] drive_next;
   wire [NUM_OUT-1:0] request;
   wire [2:0]         conflict;

   assign request = drive_cmd_reg[`BIT_DRIVE_LO +: NUM_OUT];

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_bridge
         assign conflict[g] = request[2*g] & request[2*g+1];
      end
   endgenerate

   integer i;
   always @* begin
      drive_next = {NUM_OUT{1'b0}};
      for (i = 0; i < NUM_OUT; i = i + 1) begin
         drive_next[i] = request[i]
            & (~option_cfg_reg[`BIT_PWM_EN_LO + out_number(i)] | pwm_s)
            & (~oc_flag_reg[i]
               | (option_cfg_reg[`BIT_OC_RECOV_LO + out_number(i)]
                  & recov_phase_on & ~oc_s[i]))
            & ~global_block;
         if (i < 6 && conflict[i/2]) begin
            drive_next[i] = 1'b0;
         end
      end
   end

   // Warning flag deliberately absent from gating
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         drive_on <= {NUM_OUT{1'b0}};
      end else begin
         drive_on <= drive_next;
      end
   end

endmodule

`default_nettype wire

// >>> sim/driver_map_props.sv
/* Port assertions for the driver map.
   Assumes the bind below and inputs that change between clock edges. */
`default_nettype none
module driver_map_props #(
   parameter NUM_OUT      = 8,
   parameter RECOV_CYCLES = 100
) (
   // Clock and reset
   input wire logic               clk_sys,
   input wire logic               sys_rst,
   // Link and events
   input wire logic               chip_select_low,
   input wire logic               serial_out_en,
   input wire logic               pwm_pin,
   input wire logic [NUM_OUT-1:0] over_current_in,
   input wire logic               over_volt_in,
   input wire logic               under_volt_in,
   input wire logic               thermal_sd_in,
   input wire logic               thermal_warn_in,
   // Gates
   input wire logic [NUM_OUT-1:0] drive_on
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Six samples cover two sync flops, the flag and the gate register
   sequence s_sel; !chip_select_low [*6]; endsequence
   sequence s_idle; chip_select_low [*6]; endsequence
   sequence s_quiet;
      (chip_select_low && over_current_in == '0 && !over_volt_in && !under_volt_in
       && !thermal_sd_in && $stable(pwm_pin)) [*8];
   endsequence
   property p_bridge;
      !(drive_on[0] && drive_on[1]) && !(drive_on[2] && drive_on[3])
      && !(drive_on[4] && drive_on[5]);
   endproperty
   property p_en_on; s_sel |-> serial_out_en; endproperty
   property p_en_off; s_idle |-> !serial_out_en; endproperty
   property p_tsd; thermal_sd_in [*6] |-> drive_on == '0; endproperty
   property p_ov; over_volt_in [*6] |-> drive_on == '0; endproperty
   property p_uv; under_volt_in [*6] |-> drive_on == '0; endproperty
   property p_warn;
      s_quiet ##1 $rose(thermal_warn_in) |=> $stable(drive_on) [*6];
   endproperty
   a_bridge: assert property (p_bridge) else $error("half bridge shorted");
   a_en_on: assert property (p_en_on) else $error("data out not enabled");
   a_en_off: assert property (p_en_off) else $error("data out left enabled");
   a_tsd: assert property (p_tsd) else $error("gate on in shutdown");
   a_ov: assert property (p_ov) else $error("gate on in over-voltage");
   a_uv: assert property (p_uv) else $error("gate on in under-voltage");
   a_warn: assert property (p_warn) else $error("warning moved a gate");
   for (genvar i = 0; i < NUM_OUT; i++) begin : g_oc
      property p_oc; over_current_in[i] [*6] |-> !drive_on[i]; endproperty
      a_oc: assert property (p_oc) else $error("gate on in over-current");
   end
endmodule
bind driver_spi_control_status_map driver_map_props #(
   .NUM_OUT(NUM_OUT), .RECOV_CYCLES(RECOV_CYCLES)) u_props (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .chip_select_low(chip_select_low),
   .serial_out_en(serial_out_en), .pwm_pin(pwm_pin), .over_current_in(over_current_in),
   .over_volt_in(over_volt_in), .under_volt_in(under_volt_in),
   .thermal_sd_in(thermal_sd_in), .thermal_warn_in(thermal_warn_in), .drive_on(drive_on));
`default_nettype wire

// >>> sim/spi_master_model.sv
/* Serial master model for the driver map.
   Assumes clk_sys is the bench clock; pins move on its falling edge. */
`default_nettype none
module spi_master_model (
   // Clock
   input  wire logic clk_sys,
   // Serial link
   output var  logic serial_clk_pin,
   output var  logic chip_select_low,
   output var  logic serial_in_pin,
   input  wire logic serial_out_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      serial_clk_pin = 1'b0;
      chip_select_low = 1'b1;
      serial_in_pin = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // Ten cycles a half period make the 160 ns link clock; LSB first
   task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      chip_select_low = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         serial_in_pin = tx[i];
         hold(10);
         rx[i] = serial_out_data;
         serial_clk_pin = 1'b1;
         hold(10);
         serial_clk_pin = 1'b0;
      end
      hold(10);
      chip_select_low = 1'b1;
      // Released line flips so a stale bit cannot pass as data
      serial_in_pin = ~serial_in_pin;
      hold(10);
   endtask
endmodule
`default_nettype wire

// >>> sim/driver_spi_control_status_map_test.sv
/* Self-checking bench for the driver map.
   Assumes the master model and the bound checker are compiled first. */
`default_nettype none
module driver_spi_control_status_map_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, sys_rst, serial_clk_pin, chip_select_low, serial_in_pin;
   logic        serial_out_data, serial_out_en, pwm_pin, over_volt_in, under_volt_in;
   logic        thermal_sd_in, thermal_warn_in;
   logic [7:0]  over_current_in, drive_on;
   logic [15:0] rx;
   int          n_fail = 0, checks_done = 0, cyc = 0;
   driver_spi_control_status_map #(.NUM_OUT(8), .RECOV_CYCLES(100)) dut (
      .clk_sys, .sys_rst, .serial_clk_pin, .chip_select_low, .serial_in_pin,
      .serial_out_data, .serial_out_en, .pwm_pin, .over_current_in, .over_volt_in,
      .under_volt_in, .thermal_sd_in, .thermal_warn_in, .drive_on);
   // Released data line reads inverted, so a bit taken outside the enable fails
   spi_master_model master (
      .clk_sys, .serial_clk_pin, .chip_select_low, .serial_in_pin,
      .serial_out_data (serial_out_en ? serial_out_data : ~serial_out_data));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Ceiling well above the roughly 9250 cycles the scenarios need
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail = n_fail + 1;
         report_and_stop();
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic gates(input logic [7:0] exp);
      check("drive_on", {8'h00, drive_on}, {8'h00, exp});
   endtask
   task automatic send(input logic [15:0] tx);
      master.xfer(tx, 16, rx);
      check("status_bit15", {15'h0000, rx[15]}, 16'h0001);
      wait_cyc(8);
   endtask
   task automatic on_count(input logic [15:0] exp);
      logic [15:0] on;
      on = 16'h0000;
      repeat (200) begin
         @(negedge clk_sys);
         if (drive_on[6] === 1'b1) on++;
      end
      check("on_cycles", on, exp);
   endtask
   task automatic t_reset(input int n);
      sys_rst = 1'b1;
      repeat (n) @(negedge clk_sys);
      sys_rst = 1'b0;
      // A false select edge after reset would raise the enable here
      repeat (4) begin
         @(negedge clk_sys);
         check("serial_out_en", {15'h0000, serial_out_en}, 16'h0000);
      end
      gates(8'h00);
   endtask
   task automatic t_drive;
      send(16'h018C);
      gates(8'hC6);
      send(16'h018C);
      check("status0", rx, 16'h8001);
      send(16'hF801);
      gates(8'hC6);
   endtask
   task automatic t_bridge_short;
      send(16'h01FE);
      gates(8'hC0);
      master.xfer(16'h0002, 15, rx);
      wait_cyc(8);
      gates(8'hC0);
   endtask
   task automatic t_pwm;
      send(16'h0021);
      pwm_pin = 1'b0;
      wait_cyc(6);
      gates(8'h40);
      pwm_pin = 1'b1;
      wait_cyc(6);
      gates(8'hC0);
      // Bridge output 2 low side under PWM checks the shared output numbering
      send(16'h0188);
      send(16'h0005);
      pwm_pin = 1'b0;
      wait_cyc(6);
      gates(8'hC0);
      pwm_pin = 1'b1;
      wait_cyc(6);
      gates(8'hC4);
      send(16'h0001);
   endtask
   task automatic t_oc;
      send(16'h0180);
      over_current_in = 8'h40;
      wait_cyc(10);
      over_current_in = 8'h00;
      wait_cyc(10);
      gates(8'h80);
      send(16'h0180);
      check("status0", rx, 16'h8080);
      gates(8'h80);
      send(16'h8180);
      gates(8'hC0);
      send(16'h0180);
      check("status0", rx, 16'h8001);
   endtask
   task automatic t_recov;
      send(16'h0201);
      send(16'h0180);
      over_current_in = 8'h40;
      wait_cyc(5);
      over_current_in = 8'h00;
      wait_cyc(10);
      on_count(16'd24);
      send(16'h2180);
      on_count(16'd50);
      send(16'h8180);
      send(16'h0001);
   endtask
   task automatic t_supply;
      send(16'h0180);
      over_volt_in = 1'b1;
      wait_cyc(10);
      gates(8'h00);
      over_volt_in = 1'b0;
      wait_cyc(10);
      gates(8'hC0);
      under_volt_in = 1'b1;
      wait_cyc(10);
      under_volt_in = 1'b0;
      wait_cyc(10);
      send(16'h0001);
      check("status1", rx, 16'hE000);
      send(16'h9180);
      over_volt_in = 1'b1;
      wait_cyc(10);
      over_volt_in = 1'b0;
      wait_cyc(10);
      gates(8'h00);
      send(16'h8180);
      thermal_warn_in = 1'b1;
      wait_cyc(10);
      gates(8'hC0);
      send(16'h0001);
      check("status1", rx, 16'h8800);
      thermal_warn_in = 1'b0;
      thermal_sd_in = 1'b1;
      wait_cyc(10);
      thermal_sd_in = 1'b0;
      wait_cyc(10);
      send(16'h0001);
      check("status1", rx, 16'h9800);
      gates(8'h00);
      send(16'h8180);
      gates(8'hC0);
   endtask
   initial begin
      pwm_pin = 1'b1;
      over_current_in = 8'h00;
      over_volt_in = 1'b0;
      under_volt_in = 1'b0;
      thermal_sd_in = 1'b0;
      thermal_warn_in = 1'b0;
      t_reset(6);
      t_drive();
      t_bridge_short();
      t_pwm();
      t_oc();
      t_recov();
      t_supply();
      t_reset(2);
      report_and_stop();
   end
endmodule
`default_nettype wire
